// file: facg_codec_model.sv
// codec side: loops the master clock back and measures bit and word clock periods
// assumes its inputs are registered outputs on clk_i
`timescale 1ns/10ps
module facg_codec_model (
	input wire logic clk_i,
	input wire logic mclk_i,
	input wire logic bclk_i,
	input wire logic wclk_i,
	output logic mclk_loop_o,
	output logic [15:0] m_per_b_o,
	output logic [15:0] b_per_w_o
);
	logic mq, bq, wq;
	logic [15:0] mc = '0;
	logic [15:0] bc = '0;
	assign mclk_loop_o = mclk_i;
	always @(posedge clk_i) begin
		if (bclk_i && !bq) begin
			m_per_b_o <= mc;
			mc <= '0;
		end else if (mclk_i && !mq) begin
			mc <= mc + 16'd1;
		end
		if (wclk_i && !wq) begin
			b_per_w_o <= bc;
			bc <= '0;
		end else if (bclk_i && !bq) begin
			bc <= bc + 16'd1;
		end
		mq <= mclk_i;
		bq <= bclk_i;
		wq <= wclk_i;
	end
endmodule

// file: facg_pkg.sv
// package for the field-locked audio clock generator: register map, reset values, field layout
// assumes byte-wide registers behind a two-wire serial control port
package facg_pkg;
	localparam logic [7:0] ADDR_CPF_LOW = 8'h30;
	localparam logic [7:0] ADDR_CPF_MID = 8'h31;
	localparam logic [7:0] ADDR_CPF_HIGH = 8'h32;
	localparam logic [7:0] ADDR_RSVD_A = 8'h33;
	localparam logic [7:0] ADDR_INC_LOW = 8'h34;
	localparam logic [7:0] ADDR_INC_MID = 8'h35;
	localparam logic [7:0] ADDR_INC_HIGH = 8'h36;
	localparam logic [7:0] ADDR_RSVD_B = 8'h37;
	localparam logic [7:0] ADDR_BIT_DIV = 8'h38;
	localparam logic [7:0] ADDR_WORD_DIV = 8'h39;
	localparam logic [7:0] ADDR_SETUP = 8'h3a;
	localparam logic [7:0] ADDR_RSVD_C = 8'h3b;

	localparam int CPF_W = 18;
	localparam int INC_W = 22;
	localparam int ACC_W = 23;
	localparam int RATIO_W = 6;

	localparam logic [17:0] CPF_RST = 18'h0_2DFBC;
	localparam logic [21:0] INC_RST = 22'h3A_CCCD;
	localparam logic [5:0] BIT_DIV_RST = 6'h03;
	localparam logic [5:0] WORD_DIV_RST = 6'h10;
	localparam logic [3:0] SETUP_RST = 4'h0;

	localparam int SETUP_BIT_CLOCK_PHASE_BIT = 0;
	localparam int SETUP_WORD_CLOCK_PHASE_BIT = 1;
	localparam int SETUP_MASTER_CLOCK_VOLTAGE_RANGE_BIT = 2;
	localparam int SETUP_LOCK_BIT = 3;

	localparam int SYS_CLK_KHZ = 125000;
	localparam int XTAL_REF_KHZ = 24576;
	localparam int FIELD_REF_MHZ = 59940;
	localparam int MCLK_REF_HZ = 11289600;
	localparam int BCLK_PER_WORD = 32;
	localparam int MCLK_PER_WORD = 256;

	typedef struct packed {
		logic [17:0] cpf;
		logic [21:0] inc;
		logic [5:0] bit_ratio;
		logic [5:0] word_ratio;
		logic field_lock_select;
		logic master_clock_voltage_range;
		logic word_clock_phase;
		logic bit_clock_phase;
	} facg_cfg_t;

	localparam facg_cfg_t CFG_RST = '{CPF_RST, INC_RST, BIT_DIV_RST, WORD_DIV_RST, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage

// file: facg_top.sv
// field-locked audio clock generator with its serial control port registers
// assumes scl, sda, crystal tick, field pulse and looped master clock are synchronous to SYS_CLK_I
`timescale 1ns/10ps
module facg_top #(
	parameter logic [6:0] DEV_ADDR = 7'h21, // arbitrary value
	parameter int CORR_W = 12
) (
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic XTAL_TICK_I,
	input wire logic FIELD_I,
	input wire logic MCLK_IN_I,
	output logic MCLK_OUT_O,
	output logic BCLK_O,
	output logic WCLK_O,
	output logic VRANGE_O
);
	import facg_pkg::*;

	if (CORR_W < 2 || CORR_W > 21) begin : g_chk
		$error("CORR_W out of range");
	end

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_RX = 5'b00010,
		S_ACK = 5'b00100,
		S_TX = 5'b01000,
		S_RACK = 5'b10000
	} facg_i2c_t;

	localparam logic [1:0] K_ADDR = 2'h0;
	localparam logic [1:0] K_SUB = 2'h1;
	localparam logic [1:0] K_DATA = 2'h2;

	facg_cfg_t cfg_r;
	facg_i2c_t state_r;
	logic [1:0] kind_r;
	logic rw_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	logic [7:0] sub_r;
	logic scl_q_r;
	logic sda_q_r;
	logic sda_oe_r;
	logic sda_out_r;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic wr_stb;
	logic [7:0] rd_cur;

	function automatic logic [7:0] rd_byte(input facg_cfg_t c, input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			ADDR_CPF_LOW: d = c.cpf[7:0];
			ADDR_CPF_MID: d = c.cpf[15:8];
			ADDR_CPF_HIGH: d = {6'h00, c.cpf[17:16]};
			ADDR_INC_LOW: d = c.inc[7:0];
			ADDR_INC_MID: d = c.inc[15:8];
			ADDR_INC_HIGH: d = {2'h0, c.inc[21:16]};
			ADDR_BIT_DIV: d = {2'h0, c.bit_ratio};
			ADDR_WORD_DIV: d = {2'h0, c.word_ratio};
			ADDR_SETUP: d = {4'h0, c.field_lock_select, c.master_clock_voltage_range,
				c.word_clock_phase, c.bit_clock_phase};
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	assign scl_rise = SCL_I & ~scl_q_r;
	assign scl_fall = ~SCL_I & scl_q_r;
	assign start_c = SCL_I & scl_q_r & sda_q_r & ~SDA_I;
	assign stop_c = SCL_I & scl_q_r & ~sda_q_r & SDA_I;
	assign wr_stb = (state_r == S_RX) && scl_fall && (cnt_r == 4'h8) && (kind_r == K_DATA);
	assign rd_cur = rd_byte(cfg_r, sub_r);

	// line sampling for edge and start/stop detection
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			sda_out_r <= 1'b0;
		end else begin
			scl_q_r <= SCL_I;
			sda_q_r <= SDA_I;
			sda_out_r <= 1'b0;
		end
	end

	// serial control port protocol
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state_r <= S_IDLE;
			kind_r <= K_ADDR;
			rw_r <= 1'b0;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			sub_r <= 8'h00;
			sda_oe_r <= 1'b0;
		end else if (start_c) begin
			state_r <= S_RX;
			kind_r <= K_ADDR;
			cnt_r <= 4'h0;
			sda_oe_r <= 1'b0;
		end else if (stop_c) begin
			state_r <= S_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
				S_RX: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], SDA_I};
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == 4'h8) begin
						cnt_r <= 4'h0;
						if (kind_r == K_ADDR && sh_r[7:1] != DEV_ADDR) begin
							state_r <= S_IDLE;
						end else begin
							state_r <= S_ACK;
							sda_oe_r <= 1'b1;
							if (kind_r == K_ADDR) begin
								rw_r <= sh_r[0];
							end
							if (kind_r == K_SUB) begin
								sub_r <= sh_r;
							end
							if (kind_r == K_DATA) begin
								sub_r <= sub_r + 8'h01;
							end
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						if (kind_r == K_ADDR && rw_r) begin
							state_r <= S_TX;
							sh_r <= rd_cur;
							sda_oe_r <= ~rd_cur[7];
							sub_r <= sub_r + 8'h01;
							cnt_r <= 4'h1;
						end else begin
							state_r <= S_RX;
							sda_oe_r <= 1'b0;
							kind_r <= (kind_r == K_ADDR) ? K_SUB : K_DATA;
						end
					end
				end
				S_TX: begin
					if (scl_fall) begin
						if (cnt_r == 4'h8) begin
							state_r <= S_RACK;
							sda_oe_r <= 1'b0;
							cnt_r <= 4'h0;
						end else begin
							sda_oe_r <= ~sh_r[6];
							sh_r <= {sh_r[6:0], 1'b0};
							cnt_r <= cnt_r + 4'h1;
						end
					end
				end
				S_RACK: begin
					if (scl_rise && SDA_I) begin
						state_r <= S_IDLE;
					end else if (scl_fall) begin
						state_r <= S_TX;
						sh_r <= rd_cur;
						sda_oe_r <= ~rd_cur[7];
						sub_r <= sub_r + 8'h01;
						cnt_r <= 4'h1;
					end
				end
				default: begin
					state_r <= S_IDLE;
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// register file; unused bits and reserved bytes are dropped and read zero
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cfg_r <= CFG_RST;
		end else if (wr_stb) begin
			case (sub_r)
				ADDR_CPF_LOW: cfg_r.cpf[7:0] <= sh_r;
				ADDR_CPF_MID: cfg_r.cpf[15:8] <= sh_r;
				ADDR_CPF_HIGH: cfg_r.cpf[17:16] <= sh_r[1:0];
				ADDR_INC_LOW: cfg_r.inc[7:0] <= sh_r;
				ADDR_INC_MID: cfg_r.inc[15:8] <= sh_r;
				ADDR_INC_HIGH: cfg_r.inc[21:16] <= sh_r[5:0];
				ADDR_BIT_DIV: cfg_r.bit_ratio <= sh_r[5:0];
				ADDR_WORD_DIV: cfg_r.word_ratio <= sh_r[5:0];
				ADDR_SETUP: begin
					cfg_r.field_lock_select <= sh_r[SETUP_LOCK_BIT];
					cfg_r.master_clock_voltage_range <= sh_r[SETUP_MASTER_CLOCK_VOLTAGE_RANGE_BIT];
					cfg_r.word_clock_phase <= sh_r[SETUP_WORD_CLOCK_PHASE_BIT];
					cfg_r.bit_clock_phase <= sh_r[SETUP_BIT_CLOCK_PHASE_BIT];
				end
				default: cfg_r <= cfg_r;
			endcase
		end
	end

	// numerically controlled synthesizer on crystal ticks
	logic [ACC_W-1:0] acc_r;
	logic signed [CORR_W-1:0] corr_r;
	logic [CPF_W:0] fcnt_r;
	logic msb_q_r;
	logic [INC_W-1:0] inc_eff;

	assign inc_eff = cfg_r.inc + INC_W'(signed'(corr_r));

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			acc_r <= '0;
		end else if (XTAL_TICK_I) begin
			acc_r <= acc_r + ACC_W'(inc_eff);
		end
	end

	// field lock: compare master cycles counted per field with target and trim
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			msb_q_r <= 1'b0;
			fcnt_r <= '0;
			corr_r <= '0;
		end else begin
			msb_q_r <= acc_r[ACC_W-1];
			if (FIELD_I) begin
				fcnt_r <= '0;
				if (!cfg_r.field_lock_select) begin
					corr_r <= '0;
				end else if (fcnt_r < {1'b0, cfg_r.cpf} && corr_r != {1'b0, {(CORR_W-1){1'b1}}}) begin
					corr_r <= corr_r + CORR_W'(1);
				end else if (fcnt_r > {1'b0, cfg_r.cpf} && corr_r != {1'b1, {(CORR_W-1){1'b0}}}) begin
					corr_r <= corr_r - CORR_W'(1);
				end
			end else if (acc_r[ACC_W-1] && !msb_q_r && !fcnt_r[CPF_W]) begin
				fcnt_r <= fcnt_r + 1'b1;
			end
		end
	end

	// dividers from looped-back master clock
	logic mclk_q_r;
	logic [RATIO_W:0] bdiv_r;
	logic [RATIO_W:0] wdiv_r;
	logic bclk_r;
	logic wclk_r;
	logic mclk_edge;
	logic [RATIO_W:0] bit_half;
	logic [RATIO_W:0] word_half;

	assign mclk_edge = MCLK_IN_I & ~mclk_q_r;
	assign bit_half = {1'b0, cfg_r.bit_ratio} + 1'b1;
	assign word_half = (cfg_r.word_ratio == '0) ? {1'b1, {RATIO_W{1'b0}}} : {1'b0, cfg_r.word_ratio};

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			mclk_q_r <= 1'b0;
			bdiv_r <= '0;
			wdiv_r <= '0;
			bclk_r <= 1'b0;
			wclk_r <= 1'b0;
		end else begin
			mclk_q_r <= MCLK_IN_I;
			if (mclk_edge) begin
				if (bdiv_r + 1'b1 >= bit_half) begin
					bdiv_r <= '0;
					bclk_r <= ~bclk_r;
					if (bclk_r) begin
						if (wdiv_r + 1'b1 >= word_half) begin
							wdiv_r <= '0;
							wclk_r <= ~wclk_r;
						end else begin
							wdiv_r <= wdiv_r + 1'b1;
						end
					end
				end else begin
					bdiv_r <= bdiv_r + 1'b1;
				end
			end
		end
	end

	// registered pin drivers
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			MCLK_OUT_O <= 1'b0;
			BCLK_O <= 1'b0;
			WCLK_O <= 1'b0;
			VRANGE_O <= 1'b0;
			SDA_O <= 1'b0;
			SDA_OE_O <= 1'b0;
		end else begin
			MCLK_OUT_O <= acc_r[ACC_W-1];
			BCLK_O <= bclk_r ^ cfg_r.bit_clock_phase;
			WCLK_O <= wclk_r ^ cfg_r.word_clock_phase;
			VRANGE_O <= cfg_r.master_clock_voltage_range;
			SDA_O <= sda_out_r;
			SDA_OE_O <= sda_oe_r;
		end
	end
endmodule

// file: facg_top_monitor.sv
// checker on the generator ports: serial port timing, clock causes, reset state
// assumes both clock phase bits stay zero while it runs
`timescale 1ns/10ps
module facg_top_monitor (
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic SCL_I,
	input wire logic XTAL_TICK_I,
	input wire logic MCLK_IN_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O,
	input wire logic MCLK_OUT_O,
	input wire logic BCLK_O,
	input wire logic WCLK_O,
	input wire logic VRANGE_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);
	sequence s_quiet;
		!MCLK_OUT_O && !BCLK_O && !WCLK_O && !VRANGE_O && !SDA_OE_O;
	endsequence
	sequence s_scl_fell_2ago;
		$past(SCL_I, 3) && !$past(SCL_I, 2);
	endsequence
	AST_RESET_QUIET: assert property ($rose(RSTN_I) |-> s_quiet ##1 !SDA_OE_O)
		else $error("outputs not quiet after reset");
	AST_MCLK_ON_TICK: assert property ($changed(MCLK_OUT_O) |-> $past(XTAL_TICK_I) || $past(XTAL_TICK_I, 2))
		else $error("master clock moved without a crystal tick");
	AST_SDA_LOW_ONLY: assert property (SDA_O == 1'b0)
		else $error("data line driven high");
	AST_OE_AFTER_FALL: assert property ($changed(SDA_OE_O) |-> s_scl_fell_2ago)
		else $error("data enable moved off the clock fall");
	AST_OE_STEADY: assert property (SCL_I |-> $stable(SDA_OE_O))
		else $error("data enable moved while clock high");
	AST_BCLK_ON_MCLK: assert property ($changed(BCLK_O) |-> $past(MCLK_IN_I, 2))
		else $error("bit clock moved without a master clock rise");
	AST_WCLK_ON_BCLK_FALL: assert property ($changed(WCLK_O) |-> $fell(BCLK_O) || $past(BCLK_O, 2) && !$past(BCLK_O))
		else $error("word clock moved off a bit clock fall");
	AST_VRANGE_AFTER_BYTE: assert property ($changed(VRANGE_O) |-> !SCL_I && !$past(SCL_I))
		else $error("voltage range moved outside a byte end");
endmodule
bind facg_top facg_top_monitor i_mon (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .SCL_I(SCL_I), .XTAL_TICK_I(XTAL_TICK_I),
	.MCLK_IN_I(MCLK_IN_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .MCLK_OUT_O(MCLK_OUT_O), .BCLK_O(BCLK_O),
	.WCLK_O(WCLK_O), .VRANGE_O(VRANGE_O));

// file: tb_field_locked_audio_clock_gen.sv
// bench for the audio clock generator: two-wire register access, clock ratios, master clock rate
// assumes the codec model and the bound checker are compiled with it
`timescale 1ns/10ps
module tb_field_locked_audio_clock_gen;
	import facg_pkg::*;
	localparam logic [6:0] DEV = 7'h21; // arbitrary value
	logic clk = 1'b0, rstn = 1'b0, scl = 1'b1, sda_m = 1'b1, tick = 1'b0, mq = 1'b0, wq = 1'b0;
	logic oe, sda_o, mout, mlp, bclk, wclk, vr;
	logic [15:0] mpb, bpw;
	logic [8:0] r;
	logic [7:0] rb [12];
	int num_errors = 0, comparisons = 0, tacc = 0, tcnt = 0, mr = 0, wr = 0;
	wire sda_w = oe ? 1'b0 : sda_m;
	always #4 clk = ~clk;
	facg_top #(.DEV_ADDR(DEV), .CORR_W(12)) i_dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda_w),
		.SDA_O(sda_o), .SDA_OE_O(oe), .XTAL_TICK_I(tick), .FIELD_I(1'b0), .MCLK_IN_I(mlp), .MCLK_OUT_O(mout),
		.BCLK_O(bclk), .WCLK_O(wclk), .VRANGE_O(vr));
	facg_codec_model i_codec (.clk_i(clk), .mclk_i(mout), .bclk_i(bclk), .wclk_i(wclk), .mclk_loop_o(mlp),
		.m_per_b_o(mpb), .b_per_w_o(bpw));
	always @(posedge clk) begin
		tcnt += int'(tick);
		mr += int'(mout && !mq);
		wr += int'(wclk && !wq);
		mq = mout;
		wq = wclk;
	end
	// crystal ticks at the reference rate out of the system clock
	always @(posedge clk) begin
		#1;
		tacc += XTAL_REF_KHZ;
		tick = (tacc >= SYS_CLK_KHZ);
		if (tick) tacc -= SYS_CLK_KHZ;
	end
	task automatic tally_and_finish();
		if (num_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic run(int nt, int nw);
		tcnt = 0;
		mr = 0;
		wr = 0;
		for (int i = 0; i < 40000 && (tcnt < nt || wr < nw); i++) cyc(1);
		if (tcnt < nt || wr < nw) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	// start is cond(1,0), stop is cond(0,1)
	task automatic cond(logic a, logic b);
		sda_m = a;
		cyc(4);
		scl = 1'b1;
		cyc(4);
		sda_m = b;
		cyc(4);
		scl = b;
	endtask
	task automatic xfer(logic [8:0] d);
		for (int i = 8; i >= 0; i--) begin
			sda_m = d[i];
			cyc(4);
			scl = 1'b1;
			cyc(4);
			r[i] = sda_w;
			scl = 1'b0;
		end
	endtask
	task automatic put(logic [7:0] b);
		xfer({b, 1'b1});
		chk("ack", 16'd0, 16'(r[0]));
	endtask
	task automatic read_all();
		cond(1'b1, 1'b0);
		put({DEV, 1'b0});
		put(ADDR_CPF_LOW);
		cond(1'b1, 1'b0);
		put({DEV, 1'b1});
		for (int i = 0; i < 12; i++) begin
			xfer({8'hFF, i == 11});
			rb[i] = r[8:1];
		end
		cond(1'b0, 1'b1);
	endtask
	task automatic write_all(logic [7:0] t [12]);
		cond(1'b1, 1'b0);
		put({DEV, 1'b0});
		put(ADDR_CPF_LOW);
		foreach (t[i]) put(t[i]);
		cond(1'b0, 1'b1);
	endtask
	initial begin
		#790000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		logic [7:0] t0 [12] = '{8'hBC, 8'hDF, 8'h02, 8'h00, 8'hCD, 8'hCC, 8'h3A, 8'h00, 8'h03, 8'h10, 8'h00, 8'h00};
		logic [7:0] t1 [12] = '{8'h12, 8'h34, 8'h01, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h05, 8'h08, 8'h0C, 8'h00};
		cyc(20);
		rstn = 1'b1;
		cyc(2);
		read_all();
		foreach (t0[i]) chk("start byte", 16'(t0[i]), 16'(rb[i]));
		run(0, 3);
		chk("mclk per bit", 16'd8, mpb);
		chk("bits per word", 16'(BCLK_PER_WORD), bpw);
		chk("mclk per word", 16'(MCLK_PER_WORD), 16'(mpb * bpw));
		// 4000 ticks at 11.2896 over 24.576 MHz give 1837.5 rises
		run(4000, 0);
		chk("mclk rate", 16'd1, 16'(mr >= 1836 && mr <= 1839));
		write_all(t1);
		read_all();
		foreach (t1[i]) chk("written byte", 16'(t1[i]), 16'(rb[i]));
		chk("voltage range", 16'd1, 16'(vr));
		run(0, 3);
		chk("mclk per bit", 16'd12, mpb);
		chk("bits per word", 16'd16, bpw);
		// increment of a quarter of the accumulator span: one rise per four ticks
		run(4000, 0);
		chk("mclk rate", 16'd1, 16'(mr >= 999 && mr <= 1001));
		tally_and_finish();
	end
endmodule
